// ===== logic/bar_pkg.sv
// Overview of operation
// - Four independent 48-bit address buses run concurrently
// - Each address bus: four slices, one arbiter
// - Data half: six 12-bit slices, one arbiter
// - Two data halves lock-stepped into 144 bits
// - Two isolated sets: two buses plus one half
// - Degraded: fewer address buses, one data half
// - Half failure: one or two buses, one half
// - Isolated slots take no address or data part
// - Boards partition into one to sixteen domains
// - Nonblocking 16x16 crossbar steered by data arbiters
// - Address broadcast point-to-point to non-isolated boards in the requester's domain
// - Each bus snoops one quarter of memory; the highest enabled bus also snoops the quarters of disabled buses
// - 16-byte path, 64-byte packet in four cycles
// - Each board has its own data path
// - Shared read always answered with shared block
// - Address and data paths run independently
// - Ports have slave, optional master and interrupts
// - Processor clock is 2, 3 or 4 times
// - Support board loss leaves two address buses
package bar_pkg;
  localparam int NB = 16;
  localparam int NBUS = 4;
  localparam int AW = 48;
  localparam int ADDR_SLICES = 4;
  localparam int DW = 144;
  localparam int HW = 72;
  localparam int HALVES = 2;
  localparam int DSLICES = 6;
  localparam int SW = 12;
  localparam int DOMW = 4;
  localparam int CW = 4;
  localparam int CMD_LSB = 44;
  localparam int QTR_LSB = 6;
  localparam logic [3:0] CMD_SHARED_READ_REQUEST = 4'h1;
  localparam logic [3:0] CMD_OWNERSHIP_READ_REQUEST = 4'h2;
  localparam logic [3:0] REPLY_SHARED_BLOCK = 4'h3;
  localparam logic [3:0] REPLY_UNSHARED_BLOCK = 4'h4;
  localparam logic [1:0] ADDR_SLOT_CYC = 2'h2;
  localparam logic [3:0] BEATS_FULL = 4'h4;
  localparam logic [3:0] BEATS_HALF = 4'h8;
  localparam int CFGW = 88;
endpackage : bar_pkg

// ===== logic/bar_router.sv
`timescale 1ns/1ps
module bar_router (
  input wire logic clk_sys_i, // System clock
  input wire logic nrst_i, // Asynchronous reset, active low
  input wire logic [3:0] cfg_bus_en_i, // Address bus enables
  input wire logic [1:0] cfg_half_en_i, // Data half enables
  input wire logic [1:0] set_ok_i, // Healthy flag per set
  input wire logic [15:0] slot_iso_i, // Slot isolation
  input wire logic [63:0] domain_id_i, // Domain number per slot
  input wire logic [15:0] addr_req_i, // Address request per board
  input wire logic [767:0] addr_word_i, // Address word per board
  output logic [15:0] addr_gnt_o, // Address taken pulse
  output logic [191:0] snoop_word_o, // Broadcast word per bus
  output logic [63:0] snoop_valid_o, // Snoop valid per bus and board
  output logic [15:0] reply_valid_o, // Reply pulse per board
  output logic [63:0] reply_cmd_o, // Reply code per board
  input wire logic [15:0] data_req_i, // Data request per source
  input wire logic [63:0] data_dest_i, // Destination per source
  input wire logic [2303:0] data_i, // Beat per source
  output logic [15:0] data_gnt_o, // Data grant pulse per source
  output logic [15:0] src_send_o, // Source drives beats
  output logic [2303:0] data_o, // Beat per destination
  output logic [15:0] data_valid_o, // Beat valid per destination
  output logic [63:0] data_src_o // Source of beat per destination
);

  logic [bar_pkg::CFGW-1:0] cfg_s1_q;
  logic [bar_pkg::CFGW-1:0] cfg_s2_q;
  logic [1:0] set_ok;
  logic [3:0] bus_en;
  logic [1:0] half_en;
  logic [15:0] iso;
  logic [63:0] dom;
  logic [3:0] beats;

  logic [3:0][1:0] acnt_q, acnt_d;
  logic [3:0][3:0] aptr_q, aptr_d;
  logic [3:0][47:0] sword_q, sword_d;
  logic [3:0][15:0] svalid_q, svalid_d;
  logic [15:0] agnt_q, agnt_d;
  logic [15:0] rvalid_q, rvalid_d;
  logic [15:0][3:0] rcmd_q, rcmd_d;
  logic [3:0][15:0] agrant;
  logic [15:0][1:0] tgt;
  logic [15:0] tgt_ok;

  logic [15:0][3:0] dcnt_q, dcnt_d;
  logic [15:0][3:0] dsrc_q, dsrc_d;
  logic [15:0][3:0] dptr_q, dptr_d;
  logic [15:0][3:0] dsrco_q, dsrco_d;
  logic [15:0][143:0] dout_q, dout_d;
  logic [15:0] dval_q, dval_d;
  logic [15:0] dgnt_q, dgnt_d;
  logic [15:0] send_q, send_d;
  logic [1:0] lane_live;

  // Configuration pins come from the test access side
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
    end else begin
      cfg_s1_q <= {cfg_bus_en_i, cfg_half_en_i, set_ok_i, slot_iso_i, domain_id_i};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // Set 0 holds buses 0 and 1 and data half 0, set 1 the rest
  assign set_ok = cfg_s2_q[81:80];
  assign bus_en = cfg_s2_q[87:84] & {set_ok[1], set_ok[1], set_ok[0], set_ok[0]};
  assign half_en = cfg_s2_q[83:82] & set_ok;
  assign iso = cfg_s2_q[79:64];
  assign dom = cfg_s2_q[63:0];
  assign beats = (&half_en) ? bar_pkg::BEATS_FULL : bar_pkg::BEATS_HALF;

  // Quarter of memory picks the bus; a disabled bus folds onto the highest enabled one
  function automatic logic [1:0] bar_pick_bus(input logic [1:0] q, input logic [3:0] en);
    logic [1:0] p;
    p = q;
    if (!en[q]) begin
      for (int k = 0; k < bar_pkg::NBUS; k++) begin
        if (en[k]) begin
          p = 2'(k);
        end
      end
    end
    return p;
  endfunction : bar_pick_bus

  // Disabled halves drive zero on all their slices
  function automatic logic [143:0] bar_gate(input logic [143:0] w, input logic [1:0] en);
    logic [143:0] g;
    g = w;
    for (int h = 0; h < bar_pkg::HALVES; h++) begin
      for (int k = 0; k < bar_pkg::DSLICES; k++) begin
        if (!en[h]) begin
          g[h*bar_pkg::HW+k*bar_pkg::SW +: bar_pkg::SW] = '0;
        end
      end
    end
    return g;
  endfunction : bar_gate

  always_comb begin
    for (int i = 0; i < bar_pkg::NB; i++) begin
      tgt[i] = bar_pick_bus(addr_word_i[i*bar_pkg::AW+bar_pkg::QTR_LSB +: 2], bus_en);
      tgt_ok[i] = (|bus_en) && addr_req_i[i] && !iso[i] && !agnt_q[i];
    end
  end

  // Address arbiters, one per bus, each slot two cycles
  always_comb begin
    logic found;
    logic [3:0] idx;
    logic [3:0] sel;
    found = 1'b0;
    idx = '0;
    sel = '0;
    acnt_d = acnt_q;
    aptr_d = aptr_q;
    sword_d = sword_q;
    svalid_d = svalid_q;
    agnt_d = '0;
    rvalid_d = '0;
    rcmd_d = rcmd_q;
    agrant = '0;
    for (int b = 0; b < bar_pkg::NBUS; b++) begin
      if (acnt_q[b] != 2'h0) begin
        acnt_d[b] = acnt_q[b] - 2'h1;
      end
      if (acnt_q[b] <= 2'h1) begin
        svalid_d[b] = '0;
        found = 1'b0;
        sel = '0;
        for (int k = 0; k < bar_pkg::NB; k++) begin
          idx = aptr_q[b] + 4'(k) + 4'h1;
          if (!found && tgt_ok[idx] && tgt[idx] == 2'(b)) begin
            found = 1'b1;
            sel = idx;
          end
        end
        if (found) begin
          agrant[b][sel] = 1'b1;
          agnt_d[sel] = 1'b1;
          aptr_d[b] = sel;
          acnt_d[b] = bar_pkg::ADDR_SLOT_CYC;
          sword_d[b] = addr_word_i[int'(sel)*bar_pkg::AW +: bar_pkg::AW];
          for (int j = 0; j < bar_pkg::NB; j++) begin
            svalid_d[b][j] = !iso[j] && dom[j*bar_pkg::DOMW +: bar_pkg::DOMW] ==
              dom[int'(sel)*bar_pkg::DOMW +: bar_pkg::DOMW];
          end
          if (addr_word_i[int'(sel)*bar_pkg::AW+bar_pkg::CMD_LSB +: bar_pkg::CW] ==
              bar_pkg::CMD_SHARED_READ_REQUEST) begin
            rvalid_d[sel] = 1'b1;
            rcmd_d[sel] = bar_pkg::REPLY_SHARED_BLOCK;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acnt_q <= '0;
      aptr_q <= '0;
      sword_q <= '0;
      svalid_q <= '0;
      agnt_q <= '0;
      rvalid_q <= '0;
      rcmd_q <= '0;
    end else begin
      acnt_q <= acnt_d;
      aptr_q <= aptr_d;
      sword_q <= sword_d;
      svalid_q <= svalid_d;
      agnt_q <= agnt_d;
      rvalid_q <= rvalid_d;
      rcmd_q <= rcmd_d;
    end
  end

  // Data arbiters and crossbar, separate from the address side
  always_comb begin
    logic found;
    logic [3:0] idx;
    logic [3:0] sel;
    found = 1'b0;
    idx = '0;
    sel = '0;
    dcnt_d = dcnt_q;
    dsrc_d = dsrc_q;
    dptr_d = dptr_q;
    dgnt_d = '0;
    send_d = '0;
    for (int d = 0; d < bar_pkg::NB; d++) begin
      if (dcnt_q[d] > 4'h1) begin
        send_d[dsrc_q[d]] = 1'b1;
      end
    end
    for (int d = 0; d < bar_pkg::NB; d++) begin
      dsrco_d[d] = dsrc_q[d];
      dval_d[d] = dcnt_q[d] != 4'h0;
      dout_d[d] = dval_d[d] ? bar_gate(data_i[int'(dsrc_q[d])*bar_pkg::DW +: bar_pkg::DW], half_en) : '0;
      if (dcnt_q[d] != 4'h0) begin
        dcnt_d[d] = dcnt_q[d] - 4'h1;
      end
      if (dcnt_q[d] <= 4'h1 && (|half_en) && !iso[d]) begin
        found = 1'b0;
        sel = '0;
        for (int k = 0; k < bar_pkg::NB; k++) begin
          idx = dptr_q[d] + 4'(k) + 4'h1;
          if (!found && data_req_i[idx] && !dgnt_q[idx] && !send_d[idx] && !iso[idx] &&
              data_dest_i[int'(idx)*4 +: 4] == 4'(d) &&
              dom[int'(idx)*bar_pkg::DOMW +: bar_pkg::DOMW] == dom[d*bar_pkg::DOMW +: bar_pkg::DOMW]) begin
            found = 1'b1;
            sel = idx;
          end
        end
        if (found) begin
          send_d[sel] = 1'b1;
          dgnt_d[sel] = 1'b1;
          dcnt_d[d] = beats;
          dsrc_d[d] = sel;
          dptr_d[d] = sel;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dcnt_q <= '0;
      dsrc_q <= '0;
      dptr_q <= '0;
      dsrco_q <= '0;
      dout_q <= '0;
      dval_q <= '0;
      dgnt_q <= '0;
      send_q <= '0;
    end else begin
      dcnt_q <= dcnt_d;
      dsrc_q <= dsrc_d;
      dptr_q <= dptr_d;
      dsrco_q <= dsrco_d;
      dout_q <= dout_d;
      dval_q <= dval_d;
      dgnt_q <= dgnt_d;
      send_q <= send_d;
    end
  end

  // Port outputs change only on system clock edges, so an integer-ratio core clock sees whole cycles
  assign addr_gnt_o = agnt_q;
  assign snoop_word_o = sword_q;
  assign snoop_valid_o = svalid_q;
  assign reply_valid_o = rvalid_q;
  assign reply_cmd_o = rcmd_q;
  assign data_gnt_o = dgnt_q;
  assign src_send_o = send_q;
  assign data_o = dout_q;
  assign data_valid_o = dval_q;
  assign data_src_o = dsrco_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_snoop_after_gnt: assert property (addr_gnt_o[0] |-> (|snoop_valid_o))
    else $error("grant without snoop broadcast");
  a_snoop_slot_len: assert property ($rose(|svalid_q[0]) |-> (|svalid_q[0]) [*2])
    else $error("snoop slot shorter than two cycles");
  a_shared_reply: assert property (reply_valid_o[0] |-> reply_cmd_o[3:0] == bar_pkg::REPLY_SHARED_BLOCK)
    else $error("shared read not answered with shared block");
  // Any destination showing data on each half, for the lane checks
  always_comb begin
    lane_live = '0;
    for (int d = 0; d < bar_pkg::NB; d++) begin
      for (int h = 0; h < bar_pkg::HALVES; h++) begin
        lane_live[h] = lane_live[h] | (|dout_q[d][h*bar_pkg::HW +: bar_pkg::HW]);
      end
    end
  end

  generate
    for (genvar s = 0; s < bar_pkg::NB; s++) begin : g_src_chk
      a_iso_no_dgnt: assert property (data_gnt_o[s] |-> !$past(iso[s]))
        else $error("isolated slot granted data");
      a_full_beats: assert property (data_gnt_o[s] && $past(&half_en) |-> src_send_o[s] [*4])
        else $error("full width packet not four beats");
      a_half_beats: assert property (data_gnt_o[s] && $past(^half_en) |-> src_send_o[s] [*8])
        else $error("half width packet not eight beats");
    end
  endgenerate
  a_lane_off: assert property ($past(!half_en[1]) |-> !lane_live[1])
    else $error("disabled half drives data");
  a_lane_off_lo: assert property ($past(!half_en[0]) |-> !lane_live[0])
    else $error("disabled low half drives data");
  generate
    for (genvar b = 0; b < bar_pkg::NBUS; b++) begin : g_bus_chk
      a_one_owner: assert property ($onehot0(agrant[b]))
        else $error("two boards own one address slot");
      a_bus_enabled: assert property ((|agrant[b]) |-> bus_en[b])
        else $error("grant on disabled address bus");
    end
  endgenerate

  c_shared_read: cover property (reply_valid_o[0]);
  c_half_packet: cover property (data_gnt_o[2] && $past(^half_en));
  c_back_to_back: cover property (addr_gnt_o[0] ##2 addr_gnt_o[1]);
  c_four_buses: cover property (&addr_gnt_o[11:8]);

endmodule : bar_router

// ===== sim/bar_board_model.sv
`timescale 1ns/1ps
module bar_board_model (
  input wire logic clk_sys_i, // System clock
  input wire logic nrst_i, // Reset, active low
  input wire logic [15:0] addr_post_i, // Start an address request
  input wire logic [15:0] data_post_i, // Start a packet request
  input wire logic [15:0] addr_gnt_i, // Address taken
  input wire logic [15:0] data_gnt_i, // Packet taken
  input wire logic [15:0] src_send_i, // Beat wanted this cycle
  output logic [15:0] addr_req_o, // Address request
  output logic [15:0] data_req_o, // Packet request
  output logic [2303:0] data_o // Beat per source
);
  logic [15:0] ag_q, dg_q;
  logic [3:0] beat_q [16];
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ag_q <= '0;
      dg_q <= '0;
    end else begin
      ag_q <= addr_gnt_i;
      dg_q <= data_gnt_i;
    end
  end
  // Requests stand until the falling edge after the grant is registered; address and data sides run apart
  always @(negedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_req_o <= '0;
      data_req_o <= '0;
      data_o <= '0;
      for (int s = 0; s < 16; s++) beat_q[s] <= '0;
    end else begin
      addr_req_o <= (addr_req_o | addr_post_i) & ~ag_q;
      data_req_o <= (data_req_o | data_post_i) & ~dg_q;
      // An idle source inverts its output each cycle, so its last beat returns every second cycle
      for (int s = 0; s < 16; s++) begin
        if (src_send_i[s]) begin
          data_o[144*s+:144] <= {9{4'hA, 4'(s), 8'(beat_q[s])}};
          beat_q[s] <= beat_q[s] + 4'h1;
        end else begin
          data_o[144*s+:144] <= ~data_o[144*s+:144];
          beat_q[s] <= 4'h0;
        end
      end
    end
  end
endmodule : bar_board_model

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] bus_en = 4'hF;
  logic [1:0] half_en = 2'h3;
  logic [1:0] set_ok = 2'h3;
  logic [15:0] iso = 16'h0000;
  logic [63:0] dom = '0;
  logic [15:0] apost = 16'h0000;
  logic [15:0] dpost = 16'h0000;
  logic [767:0] aword = '0;
  logic [63:0] ddest = '0;
  logic [15:0] areq, agnt, rvalid, dreq, dgnt, ssend, dvalid;
  logic [191:0] sword;
  logic [63:0] svalid, rcmd, dsrc;
  logic [2303:0] din, dout;
  int n_mismatch = 0;
  int n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  bar_router u_dut (.clk_sys_i(clk_sys), .nrst_i(nrst), .cfg_bus_en_i(bus_en), .cfg_half_en_i(half_en),
    .set_ok_i(set_ok), .slot_iso_i(iso), .domain_id_i(dom), .addr_req_i(areq), .addr_word_i(aword),
    .addr_gnt_o(agnt), .snoop_word_o(sword), .snoop_valid_o(svalid), .reply_valid_o(rvalid),
    .reply_cmd_o(rcmd), .data_req_i(dreq), .data_dest_i(ddest), .data_i(din), .data_gnt_o(dgnt),
    .src_send_o(ssend), .data_o(dout), .data_valid_o(dvalid), .data_src_o(dsrc));
  bar_board_model u_board (.clk_sys_i(clk_sys), .nrst_i(nrst), .addr_post_i(apost), .data_post_i(dpost),
    .addr_gnt_i(agnt), .data_gnt_i(dgnt), .src_send_i(ssend), .addr_req_o(areq), .data_req_o(dreq),
    .data_o(din));
  task automatic chk(input logic [143:0] got, input logic [143:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wait_bit(ref logic [15:0] v, input int b);
    for (int i = 0; i < 30; i++) begin
      tick();
      if (v[b] === 1'b1) return;
    end
    chk(1'b0, 1'b1);
  endtask : wait_bit
  // Traffic is idle whenever this is called
  task automatic cfg(input logic [3:0] be, input logic [1:0] he, input logic [1:0] ok, input logic [15:0] is);
    @(negedge clk_sys);
    bus_en = be;
    half_en = he;
    set_ok = ok;
    iso = is;
    repeat (4) @(negedge clk_sys);
  endtask : cfg
  function automatic logic [47:0] word(input int b, input logic [3:0] cmd, input logic [1:0] q);
    return {cmd, 30'h0, 4'(b), 2'h0, q, 6'h15};
  endfunction : word
  task automatic addr_xfer(input int b, input logic [3:0] cmd, input logic [1:0] q, input int bus,
                           input logic [15:0] mask);
    @(negedge clk_sys);
    aword[48*b+:48] = word(b, cmd, q);
    apost[b] <= 1'b1;
    @(negedge clk_sys);
    apost[b] <= 1'b0;
    wait_bit(agnt, b);
    chk(svalid[16*bus+:16], mask);
    chk(sword[48*bus+:48], word(b, cmd, q));
    chk(rvalid[b], cmd == bar_pkg::CMD_SHARED_READ_REQUEST);
    if (cmd == bar_pkg::CMD_SHARED_READ_REQUEST) chk(rcmd[4*b+:4], bar_pkg::REPLY_SHARED_BLOCK);
    tick();
    chk({agnt[b], svalid[16*bus+:16]}, {1'b0, mask});
  endtask : addr_xfer
  task automatic par4();
    @(negedge clk_sys);
    for (int b = 0; b < 4; b++) aword[48*(8+b)+:48] = word(8 + b, 4'h2, 2'(b));
    apost[11:8] <= 4'hF;
    @(negedge clk_sys);
    apost[11:8] <= 4'h0;
    wait_bit(agnt, 8);
    chk(agnt[11:8], 4'hF);
    chk(svalid, {4{16'hFFDE}});
  endtask : par4
  task automatic iso_test();
    cfg(4'hF, 2'h3, 2'h3, 16'h0020);
    @(negedge clk_sys);
    aword[48*5+:48] = word(5, 4'h1, 2'h0);
    ddest[23:20] = 4'h4;
    apost[5] <= 1'b1;
    dpost[5] <= 1'b1;
    @(negedge clk_sys);
    apost[5] <= 1'b0;
    dpost[5] <= 1'b0;
    repeat (12) begin
      tick();
      chk(agnt[5], 1'b0);
      chk(dgnt[5], 1'b0);
    end
  endtask : iso_test
  task automatic data_xfer(input int s, input int d, input int n, input logic [143:0] lane);
    @(negedge clk_sys);
    ddest[4*s+:4] = 4'(d);
    dpost[s] <= 1'b1;
    @(negedge clk_sys);
    dpost[s] <= 1'b0;
    wait_bit(dgnt, s);
    chk(ssend[s], 1'b1);
    for (int k = 0; k < n; k++) begin
      tick();
      chk(ssend[s], k < n - 1);
      chk(dout[144*d+:144], {9{4'hA, 4'(s), 8'(k)}} & lane);
      chk({dvalid[d], dsrc[4*d+:4]}, {1'b1, 4'(s)});
    end
    tick();
    chk(dvalid[d], 1'b0);
  endtask : data_xfer
  task automatic contend();
    int both;
    int got;
    both = 0;
    got = 0;
    @(negedge clk_sys);
    ddest[31:24] = 8'h99;
    dpost[7:6] <= 2'h3;
    @(negedge clk_sys);
    dpost[7:6] <= 2'h0;
    repeat (30) begin
      tick();
      both += int'(dgnt[7:6] === 2'h3);
      got += $countones(dgnt[7:6]);
    end
    chk(both, 0);
    chk(got, 2);
  endtask : contend
  initial begin
    #500000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    dom[3:0] = 4'h1;
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    addr_xfer(2, bar_pkg::CMD_SHARED_READ_REQUEST, 2'h1, 1, 16'hFFFE);
    addr_xfer(3, bar_pkg::CMD_OWNERSHIP_READ_REQUEST, 2'h3, 3, 16'hFFFE);
    addr_xfer(0, bar_pkg::CMD_SHARED_READ_REQUEST, 2'h0, 0, 16'h0001);
    iso_test();
    par4();
    data_xfer(1, 4, 4, {144{1'b1}});
    contend();
    cfg(4'h7, 2'h3, 2'h3, 16'h0020);
    addr_xfer(2, bar_pkg::CMD_SHARED_READ_REQUEST, 2'h3, 2, 16'hFFDE);
    cfg(4'hF, 2'h3, 2'h1, 16'h0020);
    addr_xfer(3, bar_pkg::CMD_SHARED_READ_REQUEST, 2'h3, 1, 16'hFFDE);
    data_xfer(2, 6, 8, {72'h0, {72{1'b1}}});
    cfg(4'hF, 2'h2, 2'h3, 16'h0020);
    data_xfer(3, 7, 8, {{72{1'b1}}, 72'h0});
    stop_test();
  end
endmodule : testbench
